/* rtl/mbac_checker.sv */
// mode based access checker: address translation, memory and register screening
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mbac_consts.svh"
// Notes on behaviour
// [R1] every core address is virtual, translated first
// [R2] only permitted translated accesses are forwarded
// [R3] refused or unmapped memory access resets
// [R4] register access judged per register by mode
// [R5] refused or unmapped register access resets
// [R6] segment layout group holds base and size
// [R7] permission group holds enable settings
// [R8] decision uses mode, segment and attributes
// [R9] test group is separate and checked
// [R10] coprocessor group is separate and checked
// [R11] size change immediately moves segment bounds
// [R12] enable setting grants nvm segment write
// [R13] ram mirror execute only in highest mode
// [R14] reset request one cycle later, access blocked
// [R15] mode decoded as three levels
module mbac_checker (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb register port (register groups)
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // core memory request
    input  wire mbac_pkg::mbac_req_s core_req,
    output logic [31:0]              core_rdata,
    output logic                     core_ack,
    // memory target side
    output mbac_pkg::mbac_req_s      mem_req,
    output logic [1:0]               mem_sel,
    input  wire logic [31:0]         mem_rdata,
    // security reset and interrupt
    output logic                     sec_reset_req,
    output logic                     irq
);
    import mbac_pkg::*;
    localparam int NSEG = 4;              // rom, ram, nvm, ram code mirror
    // ******************************
    // register state
    // ******************************
    mbac_mode_e   mode_reg, mode_next;                 // current privilege
    mbac_seg_s    seg_reg [NSEG], seg_next [NSEG];     // segment layout group
    logic [2:0]   en_reg, en_next;                     // permission group
    logic [1:0]   stat_reg, stat_next;                 // sticky violations
    logic [1:0]   ien_reg, ien_next;                   // interrupt enables
    logic [31:0]  test_reg, test_next;                 // test group word
    logic [31:0]  cop_reg [`MBAC_COPRO_WORDS], cop_next [`MBAC_COPRO_WORDS];
    logic [31:0]  prdata_reg, prdata_next;
    logic         pready_reg, pready_next, perr_reg, perr_next;
    logic         irq_reg, irq_next, srst_reg, srst_next;
    mbac_req_s    mreq_reg, mreq_next;
    logic [1:0]   msel_reg, msel_next;
    logic [31:0]  crd_reg, crd_next;
    logic         cack_reg, cack_next;
    // ******************************
    // memory range check
    // ******************************
    logic [NSEG-1:0] hit;
    logic [31:0]     off [NSEG];
    genvar g;
    generate
        for (g = 0; g < NSEG; g++) begin : g_seg
            mbac_seg_hit u_hit (
                .seg    (seg_reg[g]),   // live sizes move bounds at once  [R11]
                .addr   (core_req.vaddr),
                .hit    (hit[g]),
                .offset (off[g])
            );
        end
    endgenerate
    logic        mem_ok, mem_bad, mem_map;
    logic [1:0]  tsel;
    logic [31:0] paddr_t;
    // decide permission from mode, segment and attributes  [R8]
    always_comb begin
        mem_ok  = 1'b0;
        mem_map = |hit;
        tsel    = 2'd0;
        paddr_t = 32'h0000_0000;
        // lowest index wins where windows overlap
        for (int i = NSEG - 1; i >= 0; i--) begin
            if (hit[i]) begin
                tsel    = 2'(i);
                paddr_t = off[i];                          // virtual to physical  [R1]
            end
        end
        unique case (tsel)
            2'd0: mem_ok = (core_req.op != MBAC_WR);       // rom never written
            2'd1: mem_ok = (core_req.op != MBAC_EX);       // ram holds data
            2'd2: mem_ok = (core_req.op == MBAC_RD) ||
                           (core_req.op == MBAC_WR && en_reg[`MBAC_EN_NVM_WR]);  // [R12]
            2'd3: mem_ok = (core_req.op == MBAC_EX) && en_reg[`MBAC_EN_RAMMIR] &&
                           (mode_reg == MBAC_HSYS);        // [R13]
        endcase
        mem_bad = core_req.valid && !(mem_map && mem_ok);  // [R3]
    end
    // ******************************
    // register access check
    // ******************************
    logic        apb_acc, sfr_ok, sfr_map, user_lvl;
    logic [31:0] rd_val;
    // each register judged alone against the mode  [R4] [R15]
    always_comb begin
        user_lvl = (mode_reg == MBAC_USER);
        sfr_map  = 1'b1;
        sfr_ok   = !user_lvl;
        rd_val   = 32'h0000_0000;
        unique case (paddr)
            `MBAC_OFF_MODE:     rd_val = {30'h0, mode_reg};
            `MBAC_OFF_ROM_BASE: rd_val = seg_reg[0].base;  // [R6]
            `MBAC_OFF_ROM_SIZE: rd_val = seg_reg[0].size;
            `MBAC_OFF_RAM_BASE: rd_val = seg_reg[1].base;
            `MBAC_OFF_RAM_SIZE: rd_val = seg_reg[1].size;
            `MBAC_OFF_NVM_BASE: rd_val = seg_reg[2].base;
            `MBAC_OFF_NVM_SIZE: rd_val = seg_reg[2].size;
            `MBAC_OFF_MIR_BASE: rd_val = seg_reg[3].base;
            `MBAC_OFF_MIR_SIZE: rd_val = seg_reg[3].size;
            `MBAC_OFF_ENABLE: begin                        // [R7]
                rd_val = {29'h0, en_reg};
                sfr_ok = (mode_reg == MBAC_HSYS);
            end
            `MBAC_OFF_IRQ_STAT: rd_val = {30'h0, stat_reg};
            `MBAC_OFF_IRQ_CLR:  sfr_ok = !user_lvl && pwrite;
            `MBAC_OFF_IRQ_EN:   rd_val = {30'h0, ien_reg};
            `MBAC_OFF_TEST: begin                          // [R9]
                rd_val = test_reg;
                sfr_ok = (mode_reg == MBAC_HSYS) && en_reg[`MBAC_EN_TEST];
            end
            default: begin
                // coprocessor words, user mode allowed  [R10]
                if (paddr[11:4] == `MBAC_OFF_COPRO >> 4 && paddr[1:0] == 2'b00) begin
                    rd_val = cop_reg[paddr[3:2]];
                    sfr_ok = 1'b1;
                end else begin
                    sfr_map = 1'b0;
                    sfr_ok  = 1'b0;
                end
            end
        endcase
        if (paddr == `MBAC_OFF_MODE && pwrite)
            sfr_ok = (mode_reg == MBAC_HSYS);
        apb_acc = psel && penable && !pready_reg;
    end
    // ******************************
    // next state
    // ******************************
    always_comb begin
        mode_next   = mode_reg;
        seg_next    = seg_reg;
        en_next     = en_reg;
        ien_next    = ien_reg;
        test_next   = test_reg;
        cop_next    = cop_reg;
        stat_next   = stat_reg;
        prdata_next = 32'h0000_0000;
        pready_next = apb_acc;
        perr_next   = apb_acc && !(sfr_map && sfr_ok);
        mreq_next   = '0;
        msel_next   = msel_reg;
        crd_next    = 32'h0000_0000;
        cack_next   = 1'b0;
        if (apb_acc && sfr_map && sfr_ok) begin
            if (!pwrite) begin
                prdata_next = rd_val;
            end else begin
                unique case (paddr)
                    `MBAC_OFF_MODE: begin
                        if (pwdata[1:0] <= 2'd2)
                            mode_next = mbac_mode_e'(pwdata[1:0]);
                    end
                    `MBAC_OFF_ROM_BASE: seg_next[0].base = pwdata;
                    `MBAC_OFF_ROM_SIZE: seg_next[0].size = pwdata;
                    `MBAC_OFF_RAM_BASE: seg_next[1].base = pwdata;
                    `MBAC_OFF_RAM_SIZE: seg_next[1].size = pwdata;
                    `MBAC_OFF_NVM_BASE: seg_next[2].base = pwdata;
                    `MBAC_OFF_NVM_SIZE: seg_next[2].size = pwdata;
                    `MBAC_OFF_MIR_BASE: seg_next[3].base = pwdata;
                    `MBAC_OFF_MIR_SIZE: seg_next[3].size = pwdata;
                    `MBAC_OFF_ENABLE:   en_next  = pwdata[2:0];
                    // status is read-only: a write must not fall into the coprocessor words
                    `MBAC_OFF_IRQ_STAT: stat_next = stat_reg;
                    `MBAC_OFF_IRQ_CLR:  stat_next = stat_reg & ~pwdata[1:0];
                    `MBAC_OFF_IRQ_EN:   ien_next = pwdata[1:0];
                    `MBAC_OFF_TEST:     test_next = pwdata;
                    default:            cop_next[paddr[3:2]] = pwdata;
                endcase
            end
        end
        // forward only permitted accesses  [R2]
        if (core_req.valid && !mem_bad) begin
            mreq_next       = core_req;
            mreq_next.vaddr = paddr_t;
            msel_next       = tsel;
        end
        // refused access stays blocked: no forward, no data  [R14]
        cack_next = mreq_reg.valid;
        crd_next  = mreq_reg.valid && mreq_reg.op != MBAC_WR ? mem_rdata : 32'h0000_0000;
        // set wins over clear
        if (mem_bad)
            stat_next[`MBAC_IRQ_MEM] = 1'b1;
        if (perr_next)
            stat_next[`MBAC_IRQ_SFR] = 1'b1;
        irq_next  = |(stat_next & ien_next);
        // combinational cause, so the request stands one edge later  [R14]
        srst_next = mem_bad || perr_next;                 // [R3] [R5]
    end
    // ******************************
    // registers
    // ******************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg   <= MBAC_HSYS;
            for (int i = 0; i < NSEG; i++) begin
                seg_reg[i].base <= `MBAC_RST_BASE;
                seg_reg[i].size <= `MBAC_RST_SIZE;
            end
            en_reg     <= 3'b000;
            ien_reg    <= 2'b00;
            stat_reg   <= 2'b00;
            test_reg   <= 32'h0000_0000;
            for (int i = 0; i < `MBAC_COPRO_WORDS; i++)
                cop_reg[i] <= 32'h0000_0000;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            perr_reg   <= 1'b0;
            irq_reg    <= 1'b0;
            srst_reg   <= 1'b0;
            mreq_reg   <= '0;
            msel_reg   <= 2'd0;
            crd_reg    <= 32'h0000_0000;
            cack_reg   <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            seg_reg    <= seg_next;
            en_reg     <= en_next;
            ien_reg    <= ien_next;
            stat_reg   <= stat_next;
            test_reg   <= test_next;
            cop_reg    <= cop_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            perr_reg   <= perr_next;
            irq_reg    <= irq_next;
            srst_reg   <= srst_next;
            mreq_reg   <= mreq_next;
            msel_reg   <= msel_next;
            crd_reg    <= crd_next;
            cack_reg   <= cack_next;
        end
    end
    // outputs straight from flip-flops
    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = perr_reg;
    assign irq           = irq_reg;
    assign sec_reset_req = srst_reg;
    assign mem_req       = mreq_reg;
    assign mem_sel       = msel_reg;
    assign core_rdata    = crd_reg;
    assign core_ack      = cack_reg;
    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bad_mem;
        core_req.valid && !(mem_map && mem_ok);
    endsequence
    a_bad_mem_reset: assert property (s_bad_mem |=> sec_reset_req)                 // [R3]
        else $error("refused memory access gave no reset");
    a_bad_mem_block: assert property (s_bad_mem |=> !mem_req.valid)               // [R14]
        else $error("refused memory access was forwarded");
    a_fwd_allowed: assert property (mem_req.valid |-> $past(core_req.valid && mem_ok && mem_map)) // [R2]
        else $error("forwarded access was not permitted");
    a_fwd_phys: assert property (mem_req.valid |-> mem_req.vaddr == $past(paddr_t))  // [R1]
        else $error("forwarded address not translated");
    a_sfr_unmapped: assert property (apb_acc && !sfr_map |=> pslverr && sec_reset_req) // [R5]
        else $error("unmapped register gave no reset");
    a_mirror_mode: assert property (mem_req.valid && mem_sel == 2'd3 |-> $past(mode_reg) == MBAC_HSYS) // [R13]
        else $error("mirror execute outside highest mode");
    a_user_layout: assert property (apb_acc && user_lvl && paddr == `MBAC_OFF_ROM_SIZE |=> pslverr) // [R4]
        else $error("user reached layout group");
    a_mode_legal: assert property (mode_reg != 2'd3)                                // [R15]
        else $error("illegal mode code");
    a_irq_level: assert property (##1 irq == |$past(stat_next & ien_next))
        else $error("interrupt not following status");
    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule : mbac_checker
`default_nettype wire

/* rtl/mbac_consts.svh */
// constant definitions for the mode based access checker
`ifndef MBAC_CONSTS_SVH
`define MBAC_CONSTS_SVH
// ******************************
// register offsets (byte addresses)
// ******************************
`define MBAC_OFF_MODE      12'h000
`define MBAC_OFF_ROM_BASE  12'h004
`define MBAC_OFF_ROM_SIZE  12'h008
`define MBAC_OFF_RAM_BASE  12'h00C
`define MBAC_OFF_RAM_SIZE  12'h010
`define MBAC_OFF_NVM_BASE  12'h014
`define MBAC_OFF_NVM_SIZE  12'h018
`define MBAC_OFF_MIR_BASE  12'h01C
`define MBAC_OFF_MIR_SIZE  12'h020
`define MBAC_OFF_ENABLE    12'h024
`define MBAC_OFF_IRQ_STAT  12'h028
`define MBAC_OFF_IRQ_CLR   12'h02C
`define MBAC_OFF_IRQ_EN    12'h030
`define MBAC_OFF_TEST      12'h040
`define MBAC_OFF_COPRO     12'h080
`define MBAC_COPRO_WORDS   4
// ******************************
// field positions and reset values
// ******************************
`define MBAC_EN_RAMMIR     0
`define MBAC_EN_NVM_WR     1
`define MBAC_EN_TEST       2
`define MBAC_IRQ_MEM       0
`define MBAC_IRQ_SFR       1
`define MBAC_RST_MODE      2'd0
`define MBAC_RST_SIZE      32'h0000_1000
`define MBAC_RST_BASE      32'h0000_0000
`endif

/* rtl/mbac_pkg.sv */
// types shared by the access checker files
`default_nettype none
package mbac_pkg;
    // privilege levels, highest first
    typedef enum logic [1:0] {MBAC_HSYS, MBAC_SYS, MBAC_USER} mbac_mode_e;
    // memory operation kinds
    typedef enum logic [1:0] {MBAC_RD, MBAC_WR, MBAC_EX} mbac_op_e;
    // one memory request from the core
    typedef struct packed {
        logic        valid;
        mbac_op_e    op;
        logic [31:0] vaddr;
        logic [31:0] wdata;
    } mbac_req_s;
    // one segment window
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] size;
    } mbac_seg_s;
endpackage : mbac_pkg
`default_nettype wire

/* rtl/mbac_seg_hit.sv */
// one segment range comparator
`timescale 1ns/1ps
`default_nettype none
module mbac_seg_hit (
    // segment and address
    input  wire mbac_pkg::mbac_seg_s seg,
    input  wire logic [31:0]         addr,
    // result
    output logic                     hit,
    output logic [31:0]              offset
);
    import mbac_pkg::*;
    // size zero means the segment is closed; compare in 33 bits to avoid wrap
    always_comb begin
        offset = addr - seg.base;
        hit    = (addr >= seg.base) && ({1'b0, addr} < ({1'b0, seg.base} + {1'b0, seg.size}));
    end
endmodule : mbac_seg_hit
`default_nettype wire

/* test/mbac_core_model.sv */
// core and memory model facing the access checker
`timescale 1ns/1ps
`default_nettype none
module mbac_core_model (
    // clock
    input  wire logic                pclk,
    // core request and memory answer
    output mbac_pkg::mbac_req_s      core_req,
    input  wire mbac_pkg::mbac_req_s mem_req,
    output logic [31:0]              mem_rdata
);
    import mbac_pkg::*;
    // changes every cycle so a stale read never matches by luck
    logic [31:0] junk_reg = 32'h5A5A_0000;
    initial begin
        core_req = '0;
    end
    // free running garbage source
    always @(posedge pclk) begin
        junk_reg <= junk_reg + 32'h0001_0003;
    end
    // memory answers with the inverted offset only while selected
    assign mem_rdata = mem_req.valid ? ~mem_req.vaddr : junk_reg;
    // one request for one cycle, then garbage with valid low
    task automatic issue(input mbac_op_e op, input logic [31:0] a, input logic [31:0] wd);
        mbac_req_s r;
        r.valid = 1'b1;
        r.op    = op;
        r.vaddr = a;
        r.wdata = wd;
        @(posedge pclk);
        core_req <= r;
        r.valid = 1'b0;
        r.vaddr = ~a;
        r.wdata = ~wd;
        @(posedge pclk);
        core_req <= r;
    endtask : issue
endmodule : mbac_core_model
`default_nettype wire

/* test/mbac_checker_tb.sv */
// self-checking bench for the access checker
`timescale 1ns/1ps
`default_nettype none
`include "mbac_consts.svh"
module mbac_checker_tb;
    import mbac_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        core_ack, sec_reset_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, core_rdata, mem_rdata;
    logic [1:0]  mem_sel;
    mbac_req_s   core_req, mem_req;
    int          err_total = 0;
    int          compares = 0;
    mbac_checker u_mbac_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_rdata(core_rdata), .core_ack(core_ack),
        .mem_req(mem_req), .mem_sel(mem_sel), .mem_rdata(mem_rdata),
        .sec_reset_req(sec_reset_req), .irq(irq));
    mbac_core_model u_mbac_core_model (.pclk(pclk), .core_req(core_req), .mem_req(mem_req),
        .mem_rdata(mem_rdata));
    // ****************
    // checks and verdict
    // ****************
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_flag
    task automatic stop_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // ****************
    // bus and core tasks
    // ****************
    // one apb transfer; data is the write value or the expected read value
    task automatic reg_io(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the wait ends on pready; only the watchdog ends it if pready never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk_flag("pslverr", ee, pslverr);
        chk_flag("sec_reset_req", ee, sec_reset_req);
        // a refused read returns zero
        if (!w) begin
            chk_word("prdata", ee ? 32'h0000_0000 : d, prdata);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : reg_io
    // one core access; ok says whether it must be forwarded
    task automatic mem(input mbac_op_e op, input logic [31:0] a, input logic ok, input logic [1:0] sel,
                       input logic [31:0] off);
        u_mbac_core_model.issue(op, a, a ^ 32'hC0DE_0000);
        @(posedge pclk);
        chk_flag("mem_valid", ok, mem_req.valid);
        chk_flag("sec_reset_req", !ok, sec_reset_req);
        if (ok) begin
            chk_word("mem_offset", off, mem_req.vaddr);
            chk_word("mem_sel", {30'h0, sel}, {30'h0, mem_sel});
            chk_word("mem_op", {30'h0, op}, {30'h0, mem_req.op});
            if (op == MBAC_WR) begin
                chk_word("mem_wdata", a ^ 32'hC0DE_0000, mem_req.wdata);
            end
        end
        @(posedge pclk);
        chk_flag("core_ack", ok, core_ack);
        // writes and refused accesses hand back zero
        chk_word("core_rdata", (ok && op != MBAC_WR) ? ~off : 32'h0000_0000, core_rdata);
    endtask : mem
    // reset held for six cycles
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        stop_test();
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        do_reset();
        reg_io(0, `MBAC_OFF_MODE, 32'h0000_0000, 0);
        reg_io(0, `MBAC_OFF_ROM_SIZE, 32'h0000_1000, 0);
        reg_io(0, `MBAC_OFF_ENABLE, 32'h0000_0000, 0);
        reg_io(1, `MBAC_OFF_RAM_BASE, 32'h0000_2000, 0);
        reg_io(1, `MBAC_OFF_NVM_BASE, 32'h0000_4000, 0);
        reg_io(1, `MBAC_OFF_MIR_BASE, 32'h0000_6000, 0);
        reg_io(0, `MBAC_OFF_RAM_BASE, 32'h0000_2000, 0);
        $display("test reset and layout done");
        mem(MBAC_RD, 32'h0000_0010, 1, 2'd0, 32'h0000_0010);
        mem(MBAC_EX, 32'h0000_0020, 1, 2'd0, 32'h0000_0020);
        mem(MBAC_WR, 32'h0000_2020, 1, 2'd1, 32'h0000_0020);
        mem(MBAC_RD, 32'h0000_2FF0, 1, 2'd1, 32'h0000_0FF0);
        $display("test forwarding done");
        mem(MBAC_WR, 32'h0000_0010, 0, 2'd0, 32'h0000_0000);
        mem(MBAC_RD, 32'h0000_9000, 0, 2'd0, 32'h0000_0000);
        mem(MBAC_WR, 32'h0000_4008, 0, 2'd0, 32'h0000_0000);
        mem(MBAC_EX, 32'h0000_6004, 0, 2'd0, 32'h0000_0000);
        chk_flag("irq", 0, irq);
        reg_io(1, `MBAC_OFF_ENABLE, 32'h0000_0003, 0);
        mem(MBAC_WR, 32'h0000_4008, 1, 2'd2, 32'h0000_0008);
        mem(MBAC_EX, 32'h0000_6004, 1, 2'd3, 32'h0000_0004);
        mem(MBAC_RD, 32'h0000_6004, 0, 2'd0, 32'h0000_0000);
        reg_io(1, `MBAC_OFF_RAM_SIZE, 32'h0000_0100, 0);
        mem(MBAC_RD, 32'h0000_2FF0, 0, 2'd0, 32'h0000_0000);
        mem(MBAC_RD, 32'h0000_20F0, 1, 2'd1, 32'h0000_00F0);
        $display("test memory screening done");
        reg_io(0, `MBAC_OFF_IRQ_STAT, 32'h0000_0001, 0);
        reg_io(1, `MBAC_OFF_IRQ_EN, 32'h0000_0001, 0);
        repeat (2) @(posedge pclk);
        chk_flag("irq", 1, irq);
        reg_io(1, `MBAC_OFF_IRQ_CLR, 32'h0000_0001, 0);
        repeat (2) @(posedge pclk);
        chk_flag("irq", 0, irq);
        reg_io(0, `MBAC_OFF_IRQ_CLR, 32'h0000_0000, 1);
        reg_io(1, `MBAC_OFF_IRQ_EN, 32'h0000_0003, 0);
        repeat (2) @(posedge pclk);
        chk_flag("irq", 1, irq);
        reg_io(1, `MBAC_OFF_IRQ_CLR, 32'h0000_0002, 0);
        $display("test interrupt done");
        reg_io(1, `MBAC_OFF_TEST, 32'h0000_00A5, 1);
        reg_io(1, `MBAC_OFF_ENABLE, 32'h0000_0007, 0);
        reg_io(1, `MBAC_OFF_TEST, 32'h0000_00A5, 0);
        reg_io(0, `MBAC_OFF_TEST, 32'h0000_00A5, 0);
        reg_io(0, 12'h0FC, 32'h0000_0000, 1);
        reg_io(1, `MBAC_OFF_IRQ_STAT, 32'h0000_0003, 0);
        reg_io(0, `MBAC_OFF_IRQ_STAT, 32'h0000_0002, 0);
        reg_io(0, `MBAC_OFF_COPRO + 12'h008, 32'h0000_0000, 0);
        reg_io(1, `MBAC_OFF_MODE, 32'h0000_0001, 0);
        reg_io(0, `MBAC_OFF_MODE, 32'h0000_0001, 0);
        mem(MBAC_EX, 32'h0000_6004, 0, 2'd0, 32'h0000_0000);
        reg_io(0, `MBAC_OFF_ROM_SIZE, 32'h0000_1000, 0);
        reg_io(1, `MBAC_OFF_ENABLE, 32'h0000_0000, 1);
        reg_io(1, `MBAC_OFF_MODE, 32'h0000_0000, 1);
        $display("test system mode done");
        do_reset();
        chk_flag("irq", 0, irq);
        reg_io(1, `MBAC_OFF_MODE, 32'h0000_0003, 0);
        reg_io(0, `MBAC_OFF_MODE, 32'h0000_0000, 0);
        reg_io(1, `MBAC_OFF_MODE, 32'h0000_0002, 0);
        reg_io(1, `MBAC_OFF_COPRO + 12'h004, 32'h1234_5678, 0);
        reg_io(0, `MBAC_OFF_COPRO + 12'h004, 32'h1234_5678, 0);
        reg_io(0, `MBAC_OFF_ROM_SIZE, 32'h0000_0000, 1);
        reg_io(0, `MBAC_OFF_MODE, 32'h0000_0000, 1);
        mem(MBAC_RD, 32'h0000_0040, 1, 2'd0, 32'h0000_0040);
        $display("test user mode done");
        stop_test();
    end
endmodule : mbac_checker_tb
`default_nettype wire
